// ==== logic/flash_cmd_gate.sv ====
// What this block does
// (R1) command 35h switches the link to quad I/O at once
// (R2) command F5h returns the link to single I/O at once
// (R3) host sends quad enter/exit without write enable, on the current lines
// (R4) crc-64 uses the ECMA generator polynomial
// (R5) array bytes feed the crc lsb first, starting from all zeros
// (R6) computed crc is compared with the expected value, result in flag bit 4
// (R7) only a failing check stores the computed crc in the readback register
// (R8) command 96h reads the readback register lowest byte first
// (R9) readback register clears to zero when a crc operation starts; 96h reads the old value until the check ends
// (R10) readback register clears to zero on every reset
// (R11) readback starts at first location; bytes past its end read zero
// (R12) whole check: 9Bh, 27h, FFh, then eight expected bytes low first
// (R13) range check adds FEh option, four-byte start and stop, low first
// (R14) crc starts only after chip select rises following the last byte
// (R15) array reads accepted in standby and suspends, refused while busy
// (R16) read of the erase-suspended sector accepted, data flagged unsure
// (R17) status and flag status reads accepted in every state
// (R18) program accepted in standby, or erase suspend outside the suspended sector
// (R19) sector and subsector erase accepted only in standby
// (R20) status, nonvolatile config, otp program, die erase only in standby
// (R21) volatile writes, enable/disable, flag clear, lock accepted unless busy
// (R22) suspend accepted only while program, erase or a crc check runs
// (R23) flag bit 7 reads one when no self-timed operation runs
// (R24) range crc covers start through stop inclusive and counts as busy
`include "flash_cmd_regs.svh"

module flash_cmd_gate
  import flash_cmd_pkg::*;
#(
  parameter logic [31:0] ARRAY_LAST = `ARRAY_LAST_ADDR
) (
  input wire logic core_clk_i,                      // core clock, 125 MHz
  input wire logic nrst_i,                          // synchronous reset, active low
  input wire logic ce_i,                            // core clock enable
  input wire logic sclk_i,                          // serial link clock
  input wire logic cs_n_i,                          // chip select, active low
  input wire logic [3:0] serial_data_lines_i,       // data lines in
  output logic [3:0] serial_data_lines_o,           // data lines out
  output logic [3:0] serial_data_lines_oe_o,        // data line drive enables
  input wire flash_cmd_pkg::dev_state_t dev_i,      // array controller state
  output flash_cmd_pkg::cmd_out_t cmd_o,            // accepted / refused command
  output flash_cmd_pkg::mem_req_t mem_o,            // array byte request
  input wire logic mem_valid_i,                     // array byte returned
  input wire logic [7:0] mem_data_i,                // array byte
  output logic [7:0] flag_status_o,                 // flag status bits
  output logic quad_mode_o,                         // link in quad protocol
  output logic crc_busy_o                           // crc calculation running
);
  import flash_cmd_pkg::*;

  // ************************************************************
  // functions
  // ************************************************************
  function automatic cmd_class_t classify(input logic [7:0] op);
    cmd_class_t c;
    c = CL_OTHER;
    case (op)
      `OP_READ, `OP_FAST_READ: c = CL_READ;
      `OP_READ_STATUS, `OP_READ_FLAGS, `OP_CRC_READBACK: c = CL_STAT;
      `OP_PAGE_PROG: c = CL_PROG;
      `OP_SECTOR_ERASE, `OP_SUBSECTOR_ERASE: c = CL_ERASE;
      `OP_WRITE_STATUS, `OP_WRITE_NVCFG, `OP_PROG_OTP, `OP_DIE_ERASE: c = CL_WR_NV;
      `OP_WRITE_VCFG, `OP_WRITE_EVCFG, `OP_WRITE_ENABLE: c = CL_WR_VOL;
      `OP_WRITE_DISABLE, `OP_CLEAR_FLAGS, `OP_WRITE_LOCK: c = CL_WR_VOL;
      `OP_PROG_SUSPEND, `OP_ERASE_SUSPEND: c = CL_SUSP;
      `OP_QUAD_ENTER, `OP_QUAD_EXIT: c = CL_QUAD;
      `OP_IFACE_ACT: c = CL_CRC;
      default: c = CL_OTHER;
    endcase
    return c;
  endfunction

  function automatic logic allowed(input cmd_class_t c, input logic busy,
                                   input logic psus, input logic esus,
                                   input logic same_sector);
    logic ok;
    logic standby;
    standby = !busy && !psus && !esus;
    ok = 1'b1;
    case (c)
      CL_READ: ok = !busy; // R15
      CL_STAT: ok = 1'b1; // R17
      CL_PROG: ok = standby || (esus && !psus && !busy && !same_sector); // R18
      CL_ERASE: ok = standby; // R19
      CL_WR_NV: ok = standby; // R20
      CL_WR_VOL: ok = !busy; // R21
      CL_SUSP: ok = busy && !psus && !esus; // R22
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction

  function automatic logic [63:0] crc_byte(input logic [63:0] crc, input logic [7:0] d);
    logic [63:0] c;
    logic fb;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      fb = c[63] ^ d[i]; // R5
      c = {c[62:0], 1'b0} ^ (fb ? `CRC64_POLY : 64'h0); // R4
    end
    return c;
  endfunction

  function automatic logic [7:0] rb_byte(input logic [63:0] rb, input logic [4:0] idx);
    logic [7:0] b;
    b = 8'h00;
    if (idx < `READBACK_BYTES) begin
      b = rb[idx[2:0]*8 +: 8]; // R8
    end
    return b;
  endfunction

  // ************************************************************
  // link side: frame state, cleared while chip select is high
  // ************************************************************
  link_frame_t lf_r;
  link_frame_t lf_nxt;
  link_keep_t lk_r;
  link_keep_t lk_nxt;
  core_state_t s_r;
  core_state_t s_nxt;

  logic [2:0] step;
  logic [7:0] sr_in;
  logic byte_done;

  always_comb begin
    step = lk_r.quad ? 3'h4 : 3'h1;
    // quad takes a nibble per edge, single takes bit 0 only
    sr_in = lk_r.quad ? {lf_r.sr[3:0], serial_data_lines_i} :
      {lf_r.sr[6:0], serial_data_lines_i[0]};
    byte_done = (3'(lf_r.bits + step) == 3'h0);
  end

  always_comb begin
    lf_nxt = lf_r;
    lf_nxt.sr = sr_in;
    lf_nxt.bits = 3'(lf_r.bits + step);
    lf_nxt.ob = lk_r.quad ? {lf_r.ob[3:0], 4'h0} : {lf_r.ob[6:0], 1'b0};
    if (byte_done) begin
      if (lf_r.nbytes != 5'h1F) begin
        lf_nxt.nbytes = 5'(lf_r.nbytes + 5'h1);
      end
      if (lf_r.nbytes == 5'h00 && sr_in == `OP_CRC_READBACK) begin
        lf_nxt.rd = 1'b1; // R8
        lf_nxt.ob = rb_byte(lk_r.rb_copy, 5'h00); // R11
      end else if (lf_r.rd) begin
        lf_nxt.ob = rb_byte(lk_r.rb_copy, lf_r.nbytes); // R11
      end
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      lf_r <= '0;
    end else begin
      lf_r <= lf_nxt;
    end
  end

  // ************************************************************
  // link side: state that outlives a frame
  // ************************************************************
  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.rst_s = {lk_r.rst_s[1:0], nrst_i};
    lk_nxt.rb_s = {lk_r.rb_s[1:0], s_r.rb_tgl};
    if (lk_r.rb_s[1] == lk_r.rb_s[2] && lk_r.rb_s[2] != lk_r.rb_seen) begin
      lk_nxt.rb_seen = lk_r.rb_s[2];
      lk_nxt.rb_copy = s_r.rb;
    end
    if (byte_done && !cs_n_i) begin
      // bytes alternate between two slots so a quad-rate byte stays put until the core takes it
      if (lk_r.byte_tgl) begin
        lk_nxt.byte_b = sr_in;
      end else begin
        lk_nxt.byte_r = sr_in;
      end
      lk_nxt.byte_tgl = !lk_r.byte_tgl;
      if (lf_r.nbytes == 5'h00 && sr_in == `OP_QUAD_ENTER) begin
        lk_nxt.quad = 1'b1; // R1 R3
      end
      if (lf_r.nbytes == 5'h00 && sr_in == `OP_QUAD_EXIT) begin
        lk_nxt.quad = 1'b0; // R2 R3
      end
    end
    if (!lk_r.rst_s[2]) begin
      lk_nxt = '0;
      lk_nxt.rst_s = {lk_r.rst_s[1:0], nrst_i};
    end
  end

  always_ff @(posedge sclk_i) begin
    lk_r <= lk_nxt;
  end

  always_comb begin
    serial_data_lines_o = lk_r.quad ? lf_r.ob[7:4] : {2'b00, lf_r.ob[7], 1'b0};
    serial_data_lines_oe_o = 4'h0;
    if (lf_r.rd) begin
      serial_data_lines_oe_o = lk_r.quad ? 4'hF : 4'h2;
    end
  end

  // ************************************************************
  // core side: byte intake, gating and crc engine
  // ************************************************************
  logic byte_ev;
  logic frame_end;
  logic busy;
  logic [7:0] b;
  logic [4:0] k;
  cmd_class_t cls;
  logic seq_ok;
  logic whole;

  always_comb begin
    s_nxt = s_r;
    s_nxt.cmd.go = 1'b0;
    s_nxt.cmd.refused = 1'b0;
    // the synced toggle level names the slot that holds the newest byte
    b = s_r.bt_s[2] ? lk_r.byte_r : lk_r.byte_b;
    k = s_r.nbyte;
    cls = CL_OTHER;
    seq_ok = 1'b0;
    whole = 1'b0;
    busy = dev_i.pe_busy || (s_r.cst != CS_IDLE); // R24
    s_nxt.cs_s = {s_r.cs_s[1:0], cs_n_i};
    s_nxt.bt_s = {s_r.bt_s[1:0], lk_r.byte_tgl};
    s_nxt.qd_s = {s_r.qd_s[1:0], lk_r.quad};
    if (s_r.cs_s[1] == s_r.cs_s[2]) begin
      s_nxt.cs_q = s_r.cs_s[2];
    end
    if (s_r.qd_s[1] == s_r.qd_s[2]) begin
      s_nxt.qd_q = s_r.qd_s[2];
    end
    byte_ev = (s_r.bt_s[1] == s_r.bt_s[2]) && (s_r.bt_s[2] != s_r.bt_q);
    frame_end = (s_r.cs_s[1] == s_r.cs_s[2]) && s_r.cs_s[2] && !s_r.cs_q;
    if (byte_ev) begin
      s_nxt.bt_q = s_r.bt_s[2];
      if (k != 5'h1F) begin
        s_nxt.nbyte = 5'(k + 5'h1);
      end
      if (k == 5'h00) begin
        s_nxt.op = b;
        s_nxt.cmd.code = b;
        if (classify(b) == CL_STAT) begin
          s_nxt.cmd.go = 1'b1; // R17
          s_nxt.cmd.unsure = 1'b0;
        end
      end
      if (k >= 5'h01 && k <= 5'h03) begin
        s_nxt.addr = {s_r.addr[15:0], b};
      end
      if (k == 5'h01) begin
        s_nxt.sub = b;
      end
      if (k == 5'h02) begin
        s_nxt.opt = b;
      end
      if (k >= `SEQ_EXP_FIRST && k <= `SEQ_EXP_LAST) begin
        s_nxt.expct = {b, s_r.expct[63:8]}; // R12
      end else if (k > `SEQ_EXP_LAST && k <= `SEQ_START_LAST) begin
        s_nxt.start = {b, s_r.start[31:8]}; // R13
      end else if (k > `SEQ_START_LAST && k <= `SEQ_STOP_LAST) begin
        s_nxt.stop = {b, s_r.stop[31:8]}; // R13
      end
      if (k == 5'h03 && classify(s_r.op) == CL_READ) begin
        s_nxt.cmd.addr = s_nxt.addr;
        s_nxt.cmd.unsure = dev_i.erase_susp &&
          (s_nxt.addr[23 -: `SECTOR_W] == dev_i.susp_sector); // R16
        if (allowed(CL_READ, busy, dev_i.prog_susp, dev_i.erase_susp, 1'b0)) begin
          s_nxt.cmd.go = 1'b1; // R15
        end else begin
          s_nxt.cmd.refused = 1'b1; // R15
        end
      end
    end
    if (frame_end) begin
      s_nxt.nbyte = 5'h00;
      cls = classify(s_nxt.op);
      if (s_nxt.nbyte != s_r.nbyte || byte_ev) begin
        s_nxt.cmd.code = s_nxt.op;
        s_nxt.cmd.addr = s_nxt.addr;
        case (cls)
          CL_READ, CL_STAT: begin
            s_nxt.cmd.code = s_nxt.op;
          end
          CL_QUAD: begin
            s_nxt.cmd.go = 1'b1; // R1 R2
          end
          CL_CRC: begin
            whole = (s_nxt.opt == `OPT_CRC_WHOLE);
            seq_ok = (s_nxt.sub == `SUB_CRC) &&
              ((whole && (byte_ev ? 5'(k + 5'h1) : k) == `SEQ_LEN_WHOLE) ||
               (s_nxt.opt == `OPT_CRC_RANGE && (byte_ev ? 5'(k + 5'h1) : k) == `SEQ_LEN_RANGE));
            if (seq_ok && !busy && !dev_i.prog_susp && !dev_i.erase_susp) begin
              s_nxt.cmd.go = 1'b1; // R14
              // the link copy is refreshed when the check ends; a readback meanwhile
              // still shows the previous result
              s_nxt.rb = 64'h0; // R9
              s_nxt.crc = `CRC64_INIT; // R5
              s_nxt.crc_fail = 1'b0;
              s_nxt.cur = whole ? 32'h0 : s_nxt.start;
              s_nxt.last = whole ? ARRAY_LAST : s_nxt.stop; // R24
              s_nxt.cst = (!whole && s_nxt.start > s_nxt.stop) ? CS_CMP : CS_FETCH;
            end else begin
              s_nxt.cmd.refused = 1'b1;
            end
          end
          default: begin
            if (allowed(cls, busy, dev_i.prog_susp, dev_i.erase_susp,
                        s_nxt.addr[23 -: `SECTOR_W] == dev_i.susp_sector)) begin
              s_nxt.cmd.go = 1'b1;
              if (s_nxt.op == `OP_CLEAR_FLAGS) begin
                s_nxt.crc_fail = 1'b0;
              end
            end else begin
              s_nxt.cmd.refused = 1'b1;
            end
          end
        endcase
      end
    end
    case (s_r.cst)
      CS_IDLE: begin
        s_nxt.cst = s_nxt.cst;
      end
      CS_FETCH: begin
        if (mem_valid_i) begin
          s_nxt.crc = crc_byte(s_r.crc, mem_data_i); // R4 R5
          if (s_r.cur == s_r.last) begin
            s_nxt.cst = CS_CMP; // R24
          end else begin
            s_nxt.cur = s_r.cur + 32'h1;
          end
        end
      end
      CS_CMP: begin
        s_nxt.cst = CS_IDLE;
        // one toggle per check, at its end: two toggles with no link clock between
        // them would cancel and the link copy would miss a failing result
        s_nxt.rb_tgl = !s_r.rb_tgl;
        if (s_r.crc != s_r.expct) begin
          s_nxt.crc_fail = 1'b1; // R6
          s_nxt.rb = s_r.crc; // R7
        end
      end
      default: begin
        s_nxt.cst = CS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!nrst_i) begin
      s_r <= '0; // R10
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb begin
    cmd_o = s_r.cmd;
    mem_o.rd = (s_r.cst == CS_FETCH);
    mem_o.addr = s_r.cur;
    flag_status_o = 8'h00;
    flag_status_o[`FLAG_READY_BIT] = !(dev_i.pe_busy || s_r.cst != CS_IDLE); // R23
    flag_status_o[`FLAG_CRC_FAIL_BIT] = s_r.crc_fail; // R6
    quad_mode_o = s_r.qd_q;
    crc_busy_o = (s_r.cst != CS_IDLE);
  end

endmodule // flash_cmd_gate

// ==== logic/flash_cmd_regs.svh ====
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

// ************************************************************
// command codes
// ************************************************************
`define OP_QUAD_ENTER 8'h35
`define OP_QUAD_EXIT 8'hF5
`define OP_CRC_READBACK 8'h96
`define OP_IFACE_ACT 8'h9B
`define SUB_CRC 8'h27
`define OPT_CRC_WHOLE 8'hFF
`define OPT_CRC_RANGE 8'hFE
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0B
`define OP_READ_STATUS 8'h05
`define OP_READ_FLAGS 8'h70
`define OP_PAGE_PROG 8'h02
`define OP_SECTOR_ERASE 8'hD8
`define OP_SUBSECTOR_ERASE 8'h20
`define OP_WRITE_STATUS 8'h01
`define OP_WRITE_NVCFG 8'hB1
`define OP_PROG_OTP 8'h42
`define OP_DIE_ERASE 8'hC4
`define OP_WRITE_VCFG 8'h81
`define OP_WRITE_EVCFG 8'h61
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_CLEAR_FLAGS 8'h50
`define OP_WRITE_LOCK 8'hE5
`define OP_PROG_SUSPEND 8'h75
`define OP_ERASE_SUSPEND 8'hB0

// ************************************************************
// crc engine, flag bits, sequence layout
// ************************************************************
`define CRC64_POLY 64'h42F0_E1EB_A9EA_3693
`define CRC64_INIT 64'h0000_0000_0000_0000
`define FLAG_READY_BIT 7
`define FLAG_CRC_FAIL_BIT 4
`define SEQ_LEN_WHOLE 5'h0B
`define SEQ_LEN_RANGE 5'h13
`define SEQ_EXP_FIRST 5'h03
`define SEQ_EXP_LAST 5'h0A
`define SEQ_START_LAST 5'h0E
`define SEQ_STOP_LAST 5'h12
`define READBACK_BYTES 5'h08
`define SECTOR_W 8
`define ARRAY_LAST_ADDR 32'h07FF_FFFF

`endif

// ==== logic/flash_cmd_pkg.sv ====
`include "flash_cmd_regs.svh"

package flash_cmd_pkg;

  typedef enum logic [3:0] {
    CL_OTHER, CL_READ, CL_STAT, CL_PROG, CL_ERASE, CL_WR_NV, CL_WR_VOL, CL_SUSP, CL_QUAD, CL_CRC
  } cmd_class_t;

  typedef enum logic [1:0] {CS_IDLE, CS_FETCH, CS_CMP} crc_state_t;

  typedef struct packed {
    logic pe_busy;
    logic prog_susp;
    logic erase_susp;
    logic [`SECTOR_W-1:0] susp_sector;
  } dev_state_t;

  typedef struct packed {
    logic rd;
    logic [31:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic go;
    logic refused;
    logic unsure;
    logic [7:0] code;
    logic [23:0] addr;
  } cmd_out_t;

  typedef struct packed {
    logic [2:0] bits;
    logic [4:0] nbytes;
    logic [7:0] sr;
    logic rd;
    logic [7:0] ob;
  } link_frame_t;

  typedef struct packed {
    logic [2:0] rst_s;
    logic quad;
    logic [7:0] byte_r;
    logic [7:0] byte_b;
    logic byte_tgl;
    logic [2:0] rb_s;
    logic rb_seen;
    logic [63:0] rb_copy;
  } link_keep_t;

  typedef struct packed {
    logic [2:0] cs_s;
    logic cs_q;
    logic [2:0] bt_s;
    logic bt_q;
    logic [2:0] qd_s;
    logic qd_q;
    logic [4:0] nbyte;
    logic [7:0] op;
    logic [7:0] sub;
    logic [7:0] opt;
    logic [63:0] expct;
    logic [31:0] start;
    logic [31:0] stop;
    logic [23:0] addr;
    crc_state_t cst;
    logic [63:0] crc;
    logic [31:0] cur;
    logic [31:0] last;
    logic [63:0] rb;
    logic rb_tgl;
    logic crc_fail;
    cmd_out_t cmd;
  } core_state_t;

endpackage

// ==== test/flash_gate_props.sv ====
module flash_gate_props
  import flash_cmd_pkg::*;
(
  input wire logic core_clk_i, // core clock
  input wire logic nrst_i, // reset
  input wire logic ce_i, // clock enable
  input wire logic sclk_i, // link clock
  input wire logic cs_n_i, // chip select
  input wire logic [3:0] serial_data_lines_i, // data in
  input wire logic [3:0] serial_data_lines_o, // data out
  input wire logic [3:0] serial_data_lines_oe_o, // drive enables
  input wire flash_cmd_pkg::dev_state_t dev_i, // device state
  input wire flash_cmd_pkg::cmd_out_t cmd_o, // decisions
  input wire flash_cmd_pkg::mem_req_t mem_o, // array request
  input wire logic mem_valid_i, // array byte valid
  input wire logic [7:0] mem_data_i, // array byte
  input wire logic [7:0] flag_status_o, // flags
  input wire logic quad_mode_o, // quad active
  input wire logic crc_busy_o // crc running
);
  timeunit 1ns;
  timeprecision 10ps;
  // *****
  // checks
  // *****
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  go_pulse_a: assert property (cmd_o.go |=> !cmd_o.go)
    else $error("go longer than one cycle");
  go_refuse_excl_a: assert property (!(cmd_o.go && cmd_o.refused))
    else $error("go and refused together");
  ready_busy_a: assert property ((dev_i.pe_busy || crc_busy_o) &&
    $past(dev_i.pe_busy || crc_busy_o) |-> !flag_status_o[7])
    else $error("ready while busy");
  ready_idle_a: assert property (!dev_i.pe_busy && !crc_busy_o &&
    $past(!dev_i.pe_busy && !crc_busy_o) |-> flag_status_o[7])
    else $error("not ready while idle");
  flag_rsvd_a: assert property (flag_status_o[6:5] == 2'b00 && flag_status_o[3:0] == 4'h0)
    else $error("unused flag bit set");
  fail_at_end_a: assert property ($rose(flag_status_o[4]) |-> $past(crc_busy_o))
    else $error("fail flag outside crc end");
  rd_in_crc_a: assert property (mem_o.rd |-> crc_busy_o)
    else $error("fetch without crc busy");
  addr_step_a: assert property (mem_o.rd && mem_valid_i && ce_i |=>
    !mem_o.rd || mem_o.addr == $past(mem_o.addr) + 32'h1)
    else $error("fetch address did not step");
  crc_after_cs_a: assert property ($rose(mem_o.rd) |-> cs_n_i && $past(cs_n_i, 3))
    else $error("crc started inside frame");
  oe_off_a: assert property (cs_n_i |-> serial_data_lines_oe_o == 4'h0)
    else $error("drive while deselected");
  crc_go_rd_a: assert property (cmd_o.go && cmd_o.code == 8'h9B |=> mem_o.rd)
    else $error("crc go without fetch");
endmodule // flash_gate_props

bind flash_cmd_gate flash_gate_props u_props (.*);

// ==== test/spi_host_model.sv ====
module spi_host_model (
  output logic sclk_o, // link clock
  output logic cs_n_o, // chip select
  output logic [3:0] dq_o, // data to device
  input wire logic [3:0] dq_i // data from device
);
  timeunit 1ns;
  timeprecision 10ps;
  logic [127:0] rx;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    dq_o = 4'h0;
    rx = '0;
  end
  // *****
  // link clock only for reset, otherwise still outside frames
  // *****
  task automatic pulse(input int n);
    repeat (n) begin
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
  endtask
  task automatic frame(input logic [7:0] d [20], input int n, input logic qd);
    cs_n_o = 1'b0;
    for (int k = 0; k < n * 8; k += qd ? 4 : 1) begin
      #3.75 dq_o = qd ? 4'(d[k / 8] >> (4 - k % 8)) : {~dq_o[3:1], d[k / 8][7 - k % 8]};
      #3.75 sclk_o = 1'b1;
      #3.75 rx = {rx[126:0], dq_i[1]};
      #3.75 sclk_o = 1'b0;
    end
    #7.5 cs_n_o = 1'b1;
    dq_o = ~dq_o;
    #100;
  endtask
endmodule // spi_host_model

// ==== test/testbench.sv ====
module testbench;
  import flash_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 10ps;
  logic core_clk_i, nrst_i, ce_i, sclk, cs_n, mem_valid_i, quad, busy;
  logic [3:0] dq_in, dq_out, dq_oe, host_in;
  logic [7:0] mem_data_i, flags;
  logic [7:0] fb [20];
  dev_state_t dev;
  cmd_out_t cmd;
  mem_req_t mem;
  int failures, cmp_count, ngo, nref;
  localparam logic [19:0] TBL [20] = '{20'h0312B, 20'h0B33B, 20'h0500F, 20'h7000F,
    20'h02128, 20'h02339, 20'hD8008, 20'h20008, 20'h01008, 20'hB1008, 20'h42008,
    20'hC4008, 20'h8100B, 20'h6100B, 20'h0600B, 20'h0400B, 20'h5000B, 20'hE500B,
    20'h75004, 20'hB0004};
  flash_cmd_gate #(.ARRAY_LAST(32'h0000_000F)) u_dut (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .ce_i(ce_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .serial_data_lines_i(dq_in), .serial_data_lines_o(dq_out),
    .serial_data_lines_oe_o(dq_oe), .dev_i(dev), .cmd_o(cmd), .mem_o(mem),
    .mem_valid_i(mem_valid_i), .mem_data_i(mem_data_i), .flag_status_o(flags),
    .quad_mode_o(quad), .crc_busy_o(busy));
  spi_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .dq_o(dq_in), .dq_i(host_in));
  // released lines toggle with the link clock
  assign host_in = (dq_out & dq_oe) | (~dq_oe & {4{sclk}});
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // *****
  // array model, byte every other cycle
  // *****
  function automatic logic [7:0] pat(input logic [31:0] a);
    return a[7:0] * 8'h1D + 8'h5A;
  endfunction
  always @(posedge core_clk_i) begin
    if (cmd.go === 1'b1) ngo++;
    if (cmd.refused === 1'b1) nref++;
    #1;
    mem_valid_i = mem.rd && !mem_valid_i;
    mem_data_i = pat(mem.addr);
  end
  function automatic logic [63:0] crc_of(input logic [31:0] a, input logic [31:0] b);
    logic [63:0] c;
    logic [7:0] d;
    c = 64'h0;
    for (logic [31:0] x = a; x <= b; x++) begin
      d = pat(x);
      for (int i = 0; i < 8; i++) begin
        c = {c[62:0], 1'b0} ^ ((c[63] ^ d[i]) ? 64'h42F0_E1EB_A9EA_3693 : 64'h0);
      end
    end
    return c;
  endfunction
  // *****
  // shared tasks
  // *****
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task results;
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge core_clk_i);
      n++;
    end
    #1;
    if (n == 2000) begin
      failures++;
      results;
    end
  endtask
  task automatic rb_check(input logic [63:0] v);
    fb[0] = 8'h96;
    for (int i = 1; i < 10; i++) fb[i] = 8'h00;
    u_host.frame(fb, 10, 1'b0);
    for (int j = 0; j < 9; j++) begin
      chk(u_host.rx[72 - 8 * j -: 8] === (j < 8 ? v[8 * j +: 8] : 8'h00), "readback");
    end
  endtask
  task automatic crc_run(input logic rng, input logic [31:0] a, input logic [31:0] b,
                         input logic [63:0] ex);
    fb[0] = 8'h9B;
    fb[1] = 8'h27;
    fb[2] = rng ? 8'hFE : 8'hFF;
    for (int i = 0; i < 8; i++) fb[3 + i] = ex[8 * i +: 8];
    for (int i = 0; i < 4; i++) begin
      fb[11 + i] = a[8 * i +: 8];
      fb[15 + i] = b[8 * i +: 8];
    end
    u_host.frame(fb, rng ? 19 : 11, 1'b0);
    wait_idle;
  endtask
  // *****
  // scenarios
  // *****
  task automatic t_quad;
    fb[0] = 8'h35;
    u_host.frame(fb, 1, 1'b0);
    chk(quad === 1'b1, "quad on");
    fb[0] = 8'hD8;
    ngo = 0;
    u_host.frame(fb, 4, 1'b1);
    chk(ngo == 1 && cmd.code === 8'hD8, "quad command");
    fb[0] = 8'hF5;
    u_host.frame(fb, 1, 1'b1);
    chk(quad === 1'b0, "quad off");
    $display("quad test done");
  endtask
  task automatic t_gate;
    logic [19:0] e;
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk_i);
      #1 dev = '{s == 1, s == 2, s == 3, 8'h12};
      for (int r = 0; r < 20; r++) begin
        e = TBL[r];
        fb[0] = e[19:12];
        fb[1] = e[11:4];
        fb[2] = 8'h40;
        fb[3] = 8'h01;
        ngo = 0;
        nref = 0;
        u_host.frame(fb, 4, 1'b0);
        chk(ngo == e[3 - s] && nref == !e[3 - s], "gate");
        if (ngo == 1 && e[19:12] inside {8'h03, 8'h0B}) begin
          chk(cmd.addr === {e[11:4], 16'h4001}, "read address");
          chk(cmd.unsure === (s == 3 && e[11:4] == 8'h12), "unsure");
        end
        chk(flags[7] === (s != 1), "ready");
      end
    end
    @(posedge core_clk_i);
    #1 dev = '0;
    $display("gate test done");
  endtask
  task automatic t_crc;
    logic [63:0] w, r;
    w = crc_of(0, 15);
    r = crc_of(3, 9);
    crc_run(1'b1, 3, 9, r);
    chk(flags[4] === 1'b0, "range pass");
    rb_check(64'h0);
    crc_run(1'b0, 0, 0, ~w);
    chk(flags[4] === 1'b1, "whole fail");
    rb_check(w);
    crc_run(1'b1, 3, 9, r);
    rb_check(64'h0);
    $display("crc test done");
  endtask
  initial begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    mem_valid_i = 1'b0;
    mem_data_i = 8'h00;
    dev = '0;
    failures = 0;
    cmp_count = 0;
    ngo = 0;
    nref = 0;
    u_host.pulse(5);
    repeat (3) @(posedge core_clk_i);
    #1 nrst_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    rb_check(64'h0);
    t_quad;
    t_gate;
    t_crc;
    results;
  end
endmodule // testbench
